/* rtl/scc_defines.vh */
// Register map, field positions, reset values and timing counts for the sample clock control
`ifndef SCC_DEFINES_VH
`define SCC_DEFINES_VH

`define SCC_ADDR_W 8
`define SCC_DATA_W 32

`define SCC_ADDR_FIRST_CONTROL_FUNCTION_REGISTER 8'h00
`define SCC_ADDR_THIRD_CONTROL_FUNCTION_REGISTER 8'h02
`define SCC_ADDR_FOURTH_CONTROL_FUNCTION_REGISTER 8'h03
`define SCC_ADDR_STAT 8'h1B
`define SCC_ADDR_IRQ_STAT 8'h1C
`define SCC_ADDR_IRQ_CLR 8'h1D
`define SCC_ADDR_IRQ_EN 8'h1E

`define SCC_FIRST_CONTROL_FUNCTION_REGISTER_RST 32'h00000000
`define SCC_THIRD_CONTROL_FUNCTION_REGISTER_RST 32'h00000A00
`define SCC_FOURTH_CONTROL_FUNCTION_REGISTER_RST 32'h00000000

`define SCC_BIT_VCO_CAL 24
`define SCC_BIT_DAC_CAL 24
`define SCC_BIT_SYNC_EN 25
`define SCC_BIT_PLL_EN 18
`define SCC_BIT_DIV_PATH 17
`define SCC_BIT_EDGE_SEL 16
`define SCC_BIT_DOUBLER 19
`define SCC_BIT_LOCK_EN 2
`define SCC_FLD_N_LSB 8
`define SCC_FLD_N_MSB 15
`define SCC_FLD_DIV_LSB 20
`define SCC_FLD_DIV_MSB 21
`define SCC_BIT_LOCKED 24
`define SCC_BIT_VCO_BUSY 0
`define SCC_BIT_DAC_BUSY 1

`define SCC_DIV_BYPASS 2'h0
`define SCC_DIV_2 2'h1
`define SCC_DIV_4 2'h2
`define SCC_DIV_8 2'h3

`define SCC_IRQ_VCO_DONE 0
`define SCC_IRQ_DAC_DONE 1
`define SCC_IRQ_LOCK_GAIN 2
`define SCC_IRQ_LOCK_LOSS 3
`define SCC_IRQ_W 4

`define SCC_DAC_CAL_PERIODS 469632
`define SCC_SYNC_CAL_PERIODS 16
`define SCC_VCO_CAL_CYCLES 1000

`endif

/* rtl/scc_sample_clock_ctrl.v */
// Sample clock source selection, reference routing, lock status and calibration sequencing
//
// Decided for this implementation: strobed register access and the register offsets.
`include "scc_defines.vh"

module scc_sample_clock_ctrl #(
    parameter DAC_CAL_CYCLES = `SCC_DAC_CAL_PERIODS,
    parameter SYNC_CAL_EDGES = `SCC_SYNC_CAL_PERIODS,
    parameter VCO_CAL_CYCLES = `SCC_VCO_CAL_CYCLES
) (
    input wire clk,
    input wire reset,
    input wire [`SCC_ADDR_W-1:0] addr,
    input wire [`SCC_DATA_W-1:0] wdata,
    input wire wr,
    input wire rd,
    output reg [`SCC_DATA_W-1:0] rdata,
    input wire ref_clk_in,
    input wire pll_lock_in,
    input wire sync_clk_in,
    output reg sample_clk_from_pll,
    output reg pll_enable_out,
    output reg [8:0] pll_mult,
    output reg pll_in,
    output reg vco_cal_busy,
    output reg dac_cal_busy,
    output reg irq
);

    localparam ST_IDLE = 2'h0;
    localparam ST_BASE = 2'h1;
    localparam ST_SYNC = 2'h2;

    reg [`SCC_DATA_W-1:0] first_control_function_register;
    reg [`SCC_DATA_W-1:0] third_control_function_register;
    reg [`SCC_DATA_W-1:0] fourth_control_function_register;
    reg [`SCC_IRQ_W-1:0] irq_status;
    reg [`SCC_IRQ_W-1:0] irq_enable;

    // Synchronisers for asynchronous pins
    reg ref_meta;
    reg ref_sync;
    reg ref_prev;
    reg lock_meta;
    reg lock_sync;
    reg sync_meta;
    reg sync_sync;
    reg sync_prev;

    always @(posedge clk) begin
        if (reset) begin
            ref_meta <= 1'b0;
            ref_sync <= 1'b0;
            ref_prev <= 1'b0;
            lock_meta <= 1'b0;
            lock_sync <= 1'b0;
            sync_meta <= 1'b0;
            sync_sync <= 1'b0;
            sync_prev <= 1'b0;
        end else begin
            ref_meta <= ref_clk_in;
            ref_sync <= ref_meta;
            ref_prev <= ref_sync;
            lock_meta <= pll_lock_in;
            lock_sync <= lock_meta;
            sync_meta <= sync_clk_in;
            sync_sync <= sync_meta;
            sync_prev <= sync_sync;
        end
    end

    wire ref_rise = ref_sync & ~ref_prev;
    wire ref_fall = ~ref_sync & ref_prev;
    wire sync_rise = sync_sync & ~sync_prev;

    wire pll_en = third_control_function_register[`SCC_BIT_PLL_EN];
    wire div_path = third_control_function_register[`SCC_BIT_DIV_PATH];
    wire edge_sel = third_control_function_register[`SCC_BIT_EDGE_SEL];
    wire doubler = third_control_function_register[`SCC_BIT_DOUBLER];
    wire lock_en = third_control_function_register[`SCC_BIT_LOCK_EN];
    wire [7:0] fb_n = third_control_function_register[`SCC_FLD_N_MSB:`SCC_FLD_N_LSB];
    wire [1:0] div_sel = third_control_function_register[`SCC_FLD_DIV_MSB:`SCC_FLD_DIV_LSB];
    wire sync_en = fourth_control_function_register[`SCC_BIT_SYNC_EN];
    wire vco_bit = first_control_function_register[`SCC_BIT_VCO_CAL];
    wire dac_bit = fourth_control_function_register[`SCC_BIT_DAC_CAL];

    wire locked = pll_en & lock_en & lock_sync;

    // Register writes
    always @(posedge clk) begin
        if (reset) begin
            first_control_function_register <= `SCC_FIRST_CONTROL_FUNCTION_REGISTER_RST;
            third_control_function_register <= `SCC_THIRD_CONTROL_FUNCTION_REGISTER_RST;
            fourth_control_function_register <= `SCC_FOURTH_CONTROL_FUNCTION_REGISTER_RST;
            irq_enable <= {`SCC_IRQ_W{1'b0}};
        end else if (wr) begin
            case (addr)
                `SCC_ADDR_FIRST_CONTROL_FUNCTION_REGISTER: first_control_function_register <= wdata;
                `SCC_ADDR_THIRD_CONTROL_FUNCTION_REGISTER: third_control_function_register <= wdata;
                `SCC_ADDR_FOURTH_CONTROL_FUNCTION_REGISTER: fourth_control_function_register <= wdata;
                `SCC_ADDR_IRQ_EN: irq_enable <= wdata[`SCC_IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // Reference routing toward the PLL input
    reg [2:0] div_cnt;
    always @(posedge clk) begin
        if (reset) begin
            div_cnt <= 3'h0;
        end else if (ref_fall) begin
            // Counting falling edges means the divider is clocked by the inverted reference
            div_cnt <= div_cnt + 3'h1;
        end
    end

    reg next_pll_in;
    always @* begin
        next_pll_in = 1'b0;
        if (div_path) begin
            case (div_sel)
                `SCC_DIV_BYPASS: next_pll_in = ~ref_sync;
                `SCC_DIV_2: next_pll_in = div_cnt[0];
                `SCC_DIV_4: next_pll_in = div_cnt[1];
                `SCC_DIV_8: next_pll_in = div_cnt[2];
                default: next_pll_in = 1'b0;
            endcase
        end else if (doubler) begin
            // One pulse per reference edge: two per period, so the rate doubles
            next_pll_in = ref_rise | ref_fall;
        end else begin
            next_pll_in = edge_sel ? ~ref_sync : ref_sync;
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            pll_in <= 1'b0;
            sample_clk_from_pll <= 1'b0;
            pll_enable_out <= 1'b0;
            pll_mult <= 9'h000;
        end else begin
            pll_in <= next_pll_in;
            sample_clk_from_pll <= pll_en;
            pll_enable_out <= pll_en;
            pll_mult <= {fb_n, 1'b0};
        end
    end

    // Calibration triggers: only a zero-to-one change of the stored bit starts one
    reg vco_bit_q;
    reg dac_bit_q;
    always @(posedge clk) begin
        if (reset) begin
            vco_bit_q <= 1'b0;
            dac_bit_q <= 1'b0;
        end else begin
            vco_bit_q <= vco_bit;
            dac_bit_q <= dac_bit;
        end
    end
    wire vco_start = vco_bit & ~vco_bit_q;
    wire dac_start = dac_bit & ~dac_bit_q;

    // Oscillator calibration timer
    reg [15:0] vco_cnt;
    reg vco_done;
    always @(posedge clk) begin
        if (reset) begin
            vco_cnt <= 16'h0000;
            vco_cal_busy <= 1'b0;
            vco_done <= 1'b0;
        end else begin
            vco_done <= 1'b0;
            if (vco_start) begin
                vco_cnt <= VCO_CAL_CYCLES[15:0] - 16'h0001;
                vco_cal_busy <= 1'b1;
            end else if (vco_cal_busy) begin
                if (vco_cnt == 16'h0000) begin
                    vco_cal_busy <= 1'b0;
                    vco_done <= 1'b1;
                end else begin
                    vco_cnt <= vco_cnt - 16'h0001;
                end
            end
        end
    end

    // Converter timing calibration; a new trigger restarts a running one
    reg [1:0] dac_state;
    reg [19:0] dac_cnt;
    reg [4:0] sync_cnt;
    reg dac_done;
    always @(posedge clk) begin
        if (reset) begin
            dac_state <= ST_IDLE;
            dac_cnt <= 20'h00000;
            sync_cnt <= 5'h00;
            dac_cal_busy <= 1'b0;
            dac_done <= 1'b0;
        end else begin
            dac_done <= 1'b0;
            if (dac_start) begin
                dac_state <= ST_BASE;
                dac_cnt <= DAC_CAL_CYCLES[19:0] - 20'h00001;
                dac_cal_busy <= 1'b1;
            end else begin
                case (dac_state)
                    ST_IDLE: ;
                    ST_BASE: begin
                        if (dac_cnt != 20'h00000) begin
                            dac_cnt <= dac_cnt - 20'h00001;
                        end else if (sync_en) begin
                            dac_state <= ST_SYNC;
                            sync_cnt <= SYNC_CAL_EDGES[4:0];
                        end else begin
                            dac_state <= ST_IDLE;
                            dac_cal_busy <= 1'b0;
                            dac_done <= 1'b1;
                        end
                    end
                    ST_SYNC: begin
                        // Sync clock periods are counted by their rising edges
                        if (sync_cnt == 5'h00) begin
                            dac_state <= ST_IDLE;
                            dac_cal_busy <= 1'b0;
                            dac_done <= 1'b1;
                        end else if (sync_rise) begin
                            sync_cnt <= sync_cnt - 5'h01;
                        end
                    end
                    default: begin
                        dac_state <= ST_IDLE;
                        dac_cal_busy <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Interrupt status: a set in the same cycle as a clear wins
    reg locked_q;
    always @(posedge clk) begin
        if (reset) begin
            locked_q <= 1'b0;
        end else begin
            locked_q <= locked;
        end
    end

    wire [`SCC_IRQ_W-1:0] irq_events = {locked_q & ~locked, locked & ~locked_q,
                                         dac_done, vco_done};
    wire [`SCC_IRQ_W-1:0] irq_clr = (wr && addr == `SCC_ADDR_IRQ_CLR) ?
                                    wdata[`SCC_IRQ_W-1:0] : {`SCC_IRQ_W{1'b0}};
    wire [`SCC_IRQ_W-1:0] next_irq_status = (irq_status & ~irq_clr) | irq_events;

    always @(posedge clk) begin
        if (reset) begin
            irq_status <= {`SCC_IRQ_W{1'b0}};
            irq <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            irq <= |(next_irq_status & irq_enable);
        end
    end

    // Read port: data appear in the cycle after the strobe only
    reg [`SCC_DATA_W-1:0] next_rdata;
    always @* begin
        next_rdata = {`SCC_DATA_W{1'b0}};
        case (addr)
            `SCC_ADDR_FIRST_CONTROL_FUNCTION_REGISTER: next_rdata = first_control_function_register;
            `SCC_ADDR_THIRD_CONTROL_FUNCTION_REGISTER: next_rdata = third_control_function_register;
            `SCC_ADDR_FOURTH_CONTROL_FUNCTION_REGISTER: next_rdata = fourth_control_function_register;
            `SCC_ADDR_STAT: begin
                next_rdata[`SCC_BIT_LOCKED] = locked;
                next_rdata[`SCC_BIT_VCO_BUSY] = vco_cal_busy;
                next_rdata[`SCC_BIT_DAC_BUSY] = dac_cal_busy;
            end
            `SCC_ADDR_IRQ_STAT: next_rdata[`SCC_IRQ_W-1:0] = irq_status;
            `SCC_ADDR_IRQ_EN: next_rdata[`SCC_IRQ_W-1:0] = irq_enable;
            default: next_rdata = {`SCC_DATA_W{1'b0}};
        endcase
    end

    always @(posedge clk) begin
        if (reset) begin
            rdata <= {`SCC_DATA_W{1'b0}};
        end else if (rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= {`SCC_DATA_W{1'b0}};
        end
    end

endmodule // scc_sample_clock_ctrl

/* dv/scc_clock_ctrl_chk.sv */
// Port checker for the sample clock control block
module scc_clock_ctrl_chk #(
    parameter int DAC_CAL_CYCLES = 50,
    parameter int VCO_CAL_CYCLES = 8,
    parameter int SYNC_CAL_EDGES = 2
) (
    input wire clk,
    input wire reset,
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    input wire [31:0] rdata,
    input wire sample_clk_from_pll,
    input wire pll_enable_out,
    input wire [8:0] pll_mult,
    input wire vco_cal_busy,
    input wire dac_cal_busy,
    input wire irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    int busy_len;
    always @(posedge clk) begin
        if (reset || !dac_cal_busy) busy_len <= 0;
        else busy_len <= busy_len + 1;
    end
    a_mult_twice_n: assert property (
        (wr && addr == 8'h02) |-> ##2 pll_mult == {$past(wdata[15:8], 2), 1'b0})
        else $error("multiplier is not twice the divider field");
    a_source_select: assert property (
        (wr && addr == 8'h02) |-> ##2 sample_clk_from_pll == $past(wdata[18], 2))
        else $error("sample clock source does not follow its bit");
    a_enable_matches: assert property (pll_enable_out == sample_clk_from_pll)
        else $error("PLL enable differs from source select");
    a_read_idle: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data outside its cycle");
    a_lock_gated: assert property (
        (rd && addr == 8'h1B && !pll_enable_out) |=> !rdata[24])
        else $error("lock reported with PLL off");
    a_conv_trigger: assert property (
        $rose(dac_cal_busy) |-> $past(wr, 2) && $past(addr, 2) == 8'h03)
        else $error("converter calibration started without a write");
    a_osc_trigger: assert property (
        $rose(vco_cal_busy) |-> $past(wr, 2) && $past(addr, 2) == 8'h00)
        else $error("oscillator calibration started without a write");
    a_osc_length: assert property (
        $rose(vco_cal_busy) |-> vco_cal_busy [*8] ##[1:3] !vco_cal_busy)
        else $error("oscillator calibration length wrong");
    a_conv_length: assert property (
        $fell(dac_cal_busy) |-> busy_len >= DAC_CAL_CYCLES && busy_len <= DAC_CAL_CYCLES + 40)
        else $error("converter calibration length wrong");
    c_conv_done: cover property ($fell(dac_cal_busy));
    c_osc_done: cover property ($fell(vco_cal_busy));
    c_irq_up: cover property ($rose(irq));
endmodule // scc_clock_ctrl_chk

bind scc_sample_clock_ctrl scc_clock_ctrl_chk #(.DAC_CAL_CYCLES(DAC_CAL_CYCLES),
    .VCO_CAL_CYCLES(VCO_CAL_CYCLES), .SYNC_CAL_EDGES(SYNC_CAL_EDGES)) scc_clock_ctrl_chk_i (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .sample_clk_from_pll(sample_clk_from_pll), .pll_enable_out(pll_enable_out),
    .pll_mult(pll_mult), .vco_cal_busy(vco_cal_busy), .dac_cal_busy(dac_cal_busy), .irq(irq));

/* dv/scc_ref_source.sv */
// Reference source, sync clock and PLL lock seen at the block's pins
module scc_ref_source (
    input wire logic pll_en,
    input wire logic run,
    output logic ref_clk,
    output logic sync_clk,
    output logic lock
);
    timeunit 1ns;
    timeprecision 100ps;
    initial ref_clk = 1'b0;
    initial sync_clk = 1'b0;
    initial lock = 1'b0;
    // 2.5 MHz keeps even the doubled PLL input far under its ceiling
    always #200 ref_clk = run ? ~ref_clk : 1'b0;
    always #100 sync_clk = ~sync_clk;
    // Lock follows the enable after a settling time, both ways
    always @(pll_en) lock <= #500 (pll_en === 1'b1);
endmodule // scc_ref_source

/* dv/tb_scc_sample_clock_ctrl.sv */
// Self-checking bench for the sample clock control block
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fails++; \
    $display("mismatch at %0t: %h vs %h", $time, got, exp); end end
module tb_scc_sample_clock_ctrl;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0, run = 1'b1, prev;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic ref_clk, sync_clk, lock, sample_clk_from_pll, pll_enable_out, pll_in;
    logic vco_cal_busy, dac_cal_busy, irq;
    logic [8:0] pll_mult;
    int fails = 0, checks_done = 0, cycles = 0;
    always #12.5 clk = ~clk;
    scc_sample_clock_ctrl #(.DAC_CAL_CYCLES(50), .VCO_CAL_CYCLES(8), .SYNC_CAL_EDGES(2))
        scc_sample_clock_ctrl_i (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .ref_clk_in(ref_clk), .pll_lock_in(lock),
        .sync_clk_in(sync_clk), .sample_clk_from_pll(sample_clk_from_pll),
        .pll_enable_out(pll_enable_out), .pll_mult(pll_mult), .pll_in(pll_in),
        .vco_cal_busy(vco_cal_busy), .dac_cal_busy(dac_cal_busy), .irq(irq));
    scc_ref_source scc_ref_source_i (.pll_en(pll_enable_out), .run(run), .ref_clk(ref_clk),
        .sync_clk(sync_clk), .lock(lock));
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 `CHK(rdata & m, e)
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic t_reset_vals;
        `CHK(pll_mult, 9'h014)
        `CHK(sample_clk_from_pll, 1'b0)
        rd_chk(8'h02, 32'hFFFFFFFF, 32'h00000A00);
        rd_chk(8'h55, 32'hFFFFFFFF, 32'h0);
    endtask
    task automatic t_source;
        wr_reg(8'h02, 32'h0004FF04);
        wait_n(2);
        `CHK(pll_mult, 9'h1FE)
        `CHK(sample_clk_from_pll, 1'b1)
        wait_n(40);
        rd_chk(8'h1B, 32'h01000000, 32'h01000000);
        wr_reg(8'h02, 32'h00040A00);
        rd_chk(8'h1B, 32'h01000000, 32'h0);
    endtask
    task automatic t_routing;
        logic [31:0] cfg[5] = '{32'h00000A00, 32'h00010A00, 32'h00020A00, 32'h000B0A00,
            32'h00080A00};
        logic lvl[5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
        logic [31:0] rcfg[5] = '{32'h00000A00, 32'h00120A00, 32'h00220A00, 32'h00320A00,
            32'h00080A00};
        int rises[5] = '{40, 20, 10, 5, 80};
        int n;
        run <= 1'b0;
        // Let the stopped reference settle low through the pin synchroniser
        wait_n(16);
        for (int i = 0; i < 5; i++) begin
            wr_reg(8'h02, cfg[i]);
            wait_n(8);
            `CHK(pll_in, lvl[i])
        end
        run <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            wr_reg(8'h02, rcfg[i]);
            wait_n(20);
            n = 0;
            prev = pll_in;
            repeat (640) begin
                wait_n(1);
                if (pll_in && !prev) n++;
                prev = pll_in;
            end
            `CHK((n >= rises[i] - 1 && n <= rises[i] + 1), 1'b1)
        end
    endtask
    task automatic t_osc_cal;
        // Lock events from earlier scenarios would otherwise hold the interrupt up
        wr_reg(8'h1D, 32'h0000000F);
        wr_reg(8'h1E, 32'h0000000F);
        wait_n(1);
        `CHK(irq, 1'b0)
        wr_reg(8'h00, 32'h01000000);
        wait_n(12);
        `CHK({vco_cal_busy, irq}, 2'b01)
        wr_reg(8'h1E, 32'h0);
        wait_n(2);
        `CHK(irq, 1'b0)
        wr_reg(8'h1E, 32'h0000000F);
        rd_chk(8'h1C, 32'h00000001, 32'h00000001);
        wr_reg(8'h1D, 32'h00000001);
        wr_reg(8'h00, 32'h01000000);
        wait_n(3);
        `CHK({vco_cal_busy, irq}, 2'b00)
        wr_reg(8'h00, 32'h0);
    endtask
    task automatic t_conv_cal(input logic sync, input int lo, input int hi);
        int n;
        wr_reg(8'h03, {6'h0, sync, 25'h1000000});
        wr_reg(8'h03, {6'h0, sync, 25'h0});
        n = 2;
        while (dac_cal_busy === 1'b1 && n < 200) begin
            wait_n(1);
            n++;
        end
        `CHK((n >= lo && n <= hi), 1'b1)
        rd_chk(8'h1C, 32'h00000002, 32'h00000002);
        wr_reg(8'h1D, 32'h00000002);
    endtask
    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            report_and_stop();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        wait_n(3);
        t_reset_vals();
        t_source();
        t_routing();
        t_osc_cal();
        t_conv_cal(1'b0, 50, 53);
        t_conv_cal(1'b1, 58, 73);
        report_and_stop();
    end
endmodule // tb_scc_sample_clock_ctrl
